//--- rtl/qps_pkg.sv
// Constants, types and helper functions shared by the quad potentiometer serial slave.
package qps_pkg;

  localparam int          POTS            = 4;
  localparam int          REGS_PER_POT    = 4;
  localparam int          WIPER_W         = 6;
  localparam int          TAPS            = 64;
  localparam int          BYTE_BITS       = 8;
  localparam int          MEM_DEPTH       = POTS * REGS_PER_POT;
  localparam logic [3:0]  ACK_SLOT        = 4'h8;
  localparam logic [3:0]  BIT_STEP        = 4'h1;
  localparam logic [1:0]  FIRST_POT       = 2'h0;
  localparam logic [1:0]  LAST_POT        = 2'h3;
  localparam logic [1:0]  POT_STEP        = 2'h1;
  localparam logic [63:0] TAP_RESET       = 64'h0000_0000_0000_0001;
  localparam logic [5:0]  WIPER_RESET     = 6'h00;
  // Device-type nibble of the slave address; the value is arbitrary.
  localparam logic [3:0]  DEV_TYPE_DEFAULT = 4'hA;

  // Internal nonvolatile write cycle time and its length in reference clock cycles.
  localparam longint      WR_CYCLE_NS     = 5000000;
  localparam longint      REF_CLK_PERIOD_NS = 25;
  localparam int          WR_CYCLE_CYCLES = int'(WR_CYCLE_NS / REF_CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    I_GXFR_DR_WPR = 4'b0001,
    I_INCDEC      = 4'b0010,
    I_GXFR_WPR_DR = 4'b1000,
    I_RD_WPR      = 4'b1001,
    I_WR_WPR      = 4'b1010,
    I_RD_DR       = 4'b1011,
    I_WR_DR       = 4'b1100,
    I_XFR_DR_WPR  = 4'b1101,
    I_XFR_WPR_DR  = 4'b1110
  } qps_instr_e;

  typedef struct packed {
    qps_instr_e         instr;
    logic [1:0]         pot_select_field;
    logic [1:0]         register_select_field;
    logic [WIPER_W-1:0] data;
  } qps_cmd_s;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_ADDR  = 3'b001,
    L_CMD   = 3'b010,
    L_WDATA = 3'b011,
    L_RDATA = 3'b100
  } qps_lstate_e;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_EXEC = 2'b01,
    R_WAIT = 2'b10
  } qps_rstate_e;

  function automatic logic [TAPS-1:0] qps_onehot(input logic [WIPER_W-1:0] w);
    qps_onehot = TAP_RESET << w;
  endfunction

  function automatic logic qps_known(input logic [3:0] code);
    qps_known = (code == I_GXFR_DR_WPR) || (code == I_INCDEC) || (code == I_GXFR_WPR_DR) ||
                (code == I_RD_WPR) || (code == I_WR_WPR) || (code == I_RD_DR) ||
                (code == I_WR_DR) || (code == I_XFR_DR_WPR) || (code == I_XFR_WPR_DR);
  endfunction

  function automatic logic qps_is_global(input qps_instr_e i);
    qps_is_global = (i == I_GXFR_DR_WPR) || (i == I_GXFR_WPR_DR);
  endfunction

endpackage

//--- rtl/qps_regmem.sv
// Data register store: one word per pot and register, registered read data.
`timescale 1ns/1ps
`default_nettype none
module qps_regmem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 6
) (
  input  wire logic                     clk,   // Reference clock.
  input  wire logic                     we,    // Write strobe.
  input  wire logic [$clog2(DEPTH)-1:0] addr,  // Word address.
  input  wire logic [WIDTH-1:0]         wdata, // Write data.
  output logic      [WIDTH-1:0]         rdata  // Read data, one cycle after addr.
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

//--- rtl/qps_serial_slave.sv
// Two-wire serial slave, wiper registers and tap decode of the quad potentiometer.
`timescale 1ns/1ps
`default_nettype none
module qps_serial_slave
  import qps_pkg::*;
#(
  parameter int         WR_CYCLES = WR_CYCLE_CYCLES,
  parameter logic [3:0] DEV_TYPE  = DEV_TYPE_DEFAULT
) (
  input  wire logic                       ref_clk,             // Core clock, 40 MHz.
  input  wire logic                       rst_n,               // Asynchronous reset, active low.
  input  wire logic                       link_clk,            // Bus sampling clock.
  input  wire logic                       scl,                 // Serial clock from the master.
  input  wire logic                       sda_i,               // Serial data line level.
  output logic                            sda_o,               // Serial data drive value.
  output logic                            sda_oe_n,            // Low while pulling the data line.
  input  wire logic [3:0]                 address_select_pins, // Device address straps.
  output logic      [POTS-1:0][TAPS-1:0]  tap_en,              // One-hot tap switch enables.
  output logic                            write_busy           // Nonvolatile write cycle running.
);
  localparam int CNT_W = $clog2(WR_CYCLES + 1);

  // Link domain: synchronisers, edge and condition detection.
  logic        scl_s1, scl_s2, scl_d;
  logic        sda_s1, sda_s2, sda_d;
  logic [3:0]  adr_s1, adr_s2;
  logic        busy_s1, busy_s2;
  logic        ack_s1, ack_s2, ack_d;

  qps_lstate_e         lstate, next_lstate;
  logic [3:0]          bitcnt, next_bitcnt;
  logic [7:0]          shreg, next_shreg;
  logic                sda_low, next_sda_low;
  logic                ack_flag, next_ack_flag;
  qps_cmd_s            cmd_hold, next_cmd;
  logic                nv_pend, next_nv_pend;
  logic                req_tog, next_req_tog;
  logic [7:0]          tx_byte;

  // Reference domain.
  logic                req_s1, req_s2, req_d;
  qps_rstate_e         rstate;
  qps_cmd_s            cur;
  logic [1:0]          idx;
  logic [WIPER_W-1:0]  wiper [POTS];
  logic [WIPER_W-1:0]  rd_data;
  logic                ack_tog;
  logic [CNT_W-1:0]    busy_cnt;
  logic [WIPER_W-1:0]  mem_q;

  wire scl_rise  = scl_s2 & ~scl_d;
  wire scl_fall  = ~scl_s2 & scl_d;
  wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire addr_ok   = (shreg == {DEV_TYPE, adr_s2}) & ~busy_s2;
  wire cmd_ok    = qps_known(shreg[7:4]);
  wire ack_decide = ((lstate == L_ADDR) & addr_ok) |
                    ((lstate == L_CMD) & cmd_ok) |
                    (lstate == L_WDATA);
  wire tx_bit    = tx_byte[~bitcnt[2:0]];
  wire qps_instr_e instr_in = qps_instr_e'(shreg[7:4]);

  // The clock pin is an input only; the device never drives it.
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~sda_low;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_d, scl_s2, scl_s1} <= 3'h7;
      {sda_d, sda_s2, sda_s1} <= 3'h7;
      adr_s1 <= 4'h0;
      adr_s2 <= 4'h0;
      {busy_s2, busy_s1} <= 2'h0;
      {ack_d, ack_s2, ack_s1} <= 3'h0;
    end else begin
      {scl_d, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl};
      {sda_d, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_i};
      adr_s1 <= address_select_pins;
      adr_s2 <= adr_s1;
      {busy_s2, busy_s1} <= {busy_s1, write_busy};
      {ack_d, ack_s2, ack_s1} <= {ack_s2, ack_s1, ack_tog};
    end
  end

  always_comb begin
    next_lstate   = lstate;
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_sda_low  = sda_low;
    next_ack_flag = ack_flag;
    next_cmd      = cmd_hold;
    next_nv_pend  = nv_pend;
    next_req_tog  = req_tog;
    if (start_det) begin
      // A start at any point drops a partial byte and any unfinished write.
      next_lstate  = L_ADDR;
      next_bitcnt  = 4'h0;
      next_sda_low = 1'b0;
      next_nv_pend = 1'b0;
    end else if (stop_det) begin
      next_lstate  = L_IDLE;
      next_bitcnt  = 4'h0;
      next_sda_low = 1'b0;
      next_nv_pend = 1'b0;
      if (nv_pend) begin
        next_req_tog = ~req_tog;
      end
    end else if (scl_rise && lstate != L_IDLE) begin
      if (bitcnt != ACK_SLOT) begin
        next_shreg  = {shreg[6:0], sda_s2};
        next_bitcnt = 4'(bitcnt + BIT_STEP);
      end else begin
        next_bitcnt = 4'h0;
        next_lstate = L_IDLE;
        if (ack_flag) begin
          unique case (lstate)
            L_ADDR: begin
              next_lstate = L_CMD;
            end
            L_CMD: begin
              next_cmd.instr                 = instr_in;
              next_cmd.pot_select_field      = shreg[3:2];
              next_cmd.register_select_field = shreg[1:0];
              unique case (instr_in)
                I_RD_WPR, I_RD_DR: begin
                  next_lstate  = L_RDATA;
                  next_req_tog = ~req_tog;
                end
                I_WR_WPR, I_WR_DR: begin
                  next_lstate = L_WDATA;
                end
                I_XFR_DR_WPR, I_GXFR_DR_WPR: begin
                  next_req_tog = ~req_tog;
                end
                I_XFR_WPR_DR, I_GXFR_WPR_DR: begin
                  next_nv_pend = 1'b1;
                end
                default: begin
                end
              endcase
            end
            L_WDATA: begin
              next_cmd.data = shreg[WIPER_W-1:0];
              if (cmd_hold.instr == I_WR_WPR) begin
                next_req_tog = ~req_tog;
              end else begin
                next_nv_pend = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end else if (scl_fall) begin
      // Drive changes only follow a falling clock, so data is stable while it is high.
      if (lstate != L_IDLE && bitcnt == ACK_SLOT) begin
        next_ack_flag = (lstate != L_RDATA) & ack_decide;
        next_sda_low  = (lstate != L_RDATA) & ack_decide;
      end else if (lstate == L_RDATA) begin
        next_sda_low = ~tx_bit;
      end else begin
        next_sda_low = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lstate   <= L_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      sda_low  <= 1'b0;
      ack_flag <= 1'b0;
      cmd_hold <= '0;
      nv_pend  <= 1'b0;
      req_tog  <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      lstate   <= next_lstate;
      bitcnt   <= next_bitcnt;
      shreg    <= next_shreg;
      sda_low  <= next_sda_low;
      ack_flag <= next_ack_flag;
      cmd_hold <= next_cmd;
      nv_pend  <= next_nv_pend;
      req_tog  <= next_req_tog;
      if (ack_s2 != ack_d) begin
        tx_byte <= {{(BYTE_BITS - WIPER_W){1'b0}}, rd_data};
      end
    end
  end

  // Reference domain: executes commands handed over by toggle.
  wire new_req    = req_s2 ^ req_d;
  wire reads_mem  = (cur.instr == I_RD_DR) | (cur.instr == I_XFR_DR_WPR) | (cur.instr == I_GXFR_DR_WPR);
  wire writes_mem = (cur.instr == I_WR_DR) | (cur.instr == I_XFR_WPR_DR) | (cur.instr == I_GXFR_WPR_DR);
  wire is_global  = qps_is_global(cur.instr);
  wire last_step  = ~is_global | (idx == LAST_POT);
  wire step_done  = ((rstate == R_EXEC) & ~reads_mem) | (rstate == R_WAIT);
  wire mem_we     = (rstate == R_EXEC) & writes_mem;
  wire [WIPER_W-1:0] mem_wd = (cur.instr == I_WR_DR) ? cur.data : wiper[idx];
  wire wiper_we   = ((rstate == R_EXEC) & (cur.instr == I_WR_WPR)) |
                    ((rstate == R_WAIT) & (cur.instr != I_RD_DR));
  wire [WIPER_W-1:0] wiper_wd = (rstate == R_WAIT) ? mem_q : cur.data;

  qps_regmem #(
    .DEPTH (MEM_DEPTH),
    .WIDTH (WIPER_W)
  ) u_regmem (
    .clk   (ref_clk),
    .we    (mem_we),
    .addr  ({idx, cur.register_select_field}),
    .wdata (mem_wd),
    .rdata (mem_q)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {req_d, req_s2, req_s1} <= 3'h0;
      rstate  <= R_IDLE;
      cur     <= '0;
      idx     <= FIRST_POT;
      ack_tog <= 1'b0;
      rd_data <= WIPER_RESET;
    end else begin
      {req_d, req_s2, req_s1} <= {req_s2, req_s1, req_tog};
      unique case (rstate)
        R_IDLE: begin
          if (new_req) begin
            cur    <= cmd_hold;
            idx    <= qps_is_global(cmd_hold.instr) ? FIRST_POT : cmd_hold.pot_select_field;
            rstate <= R_EXEC;
          end
        end
        R_EXEC: begin
          rstate <= reads_mem ? R_WAIT : (last_step ? R_IDLE : R_EXEC);
        end
        R_WAIT: begin
          rstate <= last_step ? R_IDLE : R_EXEC;
        end
        default: begin
          rstate <= R_IDLE;
        end
      endcase
      if (step_done && !last_step) begin
        idx <= 2'(idx + POT_STEP);
      end
      if (step_done && last_step) begin
        ack_tog <= ~ack_tog;
      end
      if (rstate == R_EXEC && cur.instr == I_RD_WPR) begin
        rd_data <= wiper[idx];
      end else if (rstate == R_WAIT && cur.instr == I_RD_DR) begin
        rd_data <= mem_q;
      end
    end
  end

  // The busy cycle starts on the last data-register write of a nonvolatile command.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt   <= '0;
      write_busy <= 1'b0;
    end else if (mem_we && last_step) begin
      busy_cnt   <= CNT_W'(WR_CYCLES - 1);
      write_busy <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= CNT_W'(busy_cnt - 1'b1);
    end else begin
      write_busy <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < POTS; p++) begin
        wiper[p]  <= WIPER_RESET;
        tap_en[p] <= TAP_RESET;
      end
    end else begin
      if (wiper_we) begin
        wiper[idx] <= wiper_wd;
      end
      for (int p = 0; p < POTS; p++) begin
        tap_en[p] <= qps_onehot(wiper[p]);
      end
    end
  end

  logic taps_onehot;
  always_comb begin
    taps_onehot = 1'b1;
    for (int p = 0; p < POTS; p++) begin
      taps_onehot = taps_onehot & $onehot(tap_en[p]);
    end
  end

  a_drive_needs_frame: assert property (@(posedge link_clk) disable iff (!rst_n)
    (!sda_oe_n && lstate == L_IDLE) |-> scl_d)
    else $error("Data line pulled low outside a transfer.");

  a_idle_releases: assert property (@(posedge link_clk) disable iff (!rst_n)
    (lstate == L_IDLE && scl_fall && !start_det) |=> sda_oe_n)
    else $error("Data line not released while idle.");

  a_start_to_addr: assert property (@(posedge link_clk) disable iff (!rst_n)
    start_det |=> (lstate == L_ADDR) && (bitcnt == 4'h0) && sda_oe_n)
    else $error("Start did not restart address reception.");

  a_stop_to_idle: assert property (@(posedge link_clk) disable iff (!rst_n)
    stop_det |=> (lstate == L_IDLE) && sda_oe_n && !nv_pend)
    else $error("Stop did not return to idle.");

  a_addr_mismatch_quiet: assert property (@(posedge link_clk) disable iff (!rst_n)
    (lstate == L_ADDR && scl_fall && bitcnt == ACK_SLOT && shreg[3:0] != adr_s2 && !start_det && !stop_det)
    |=> sda_oe_n)
    else $error("Acknowledged a foreign address.");

  a_busy_no_ack: assert property (@(posedge link_clk) disable iff (!rst_n)
    (lstate == L_ADDR && busy_s2 && scl_fall && bitcnt == ACK_SLOT && !start_det && !stop_det) |=> sda_oe_n)
    else $error("Address acknowledged during write cycle.");

  a_drive_after_fall: assert property (@(posedge link_clk) disable iff (!rst_n)
    ($changed(sda_oe_n) && !$past(start_det) && !$past(stop_det)) |-> $past(scl_fall))
    else $error("Data drive changed away from a falling clock.");

  a_taps_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    taps_onehot)
    else $error("Tap enables not one-hot.");

  a_tap_follows_wiper: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wiper_we && idx == 2'h2) |=> ##1 tap_en[2] == qps_onehot($past(wiper_wd, 2)))
    else $error("Tap enables do not follow the wiper.");

  a_busy_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mem_we && last_step) |=> write_busy [*8])
    else $error("Write cycle ended too soon.");
endmodule
`default_nettype wire

//--- tb/qps_bus_master.sv
// Behavioural two-wire bus master that makes the serial clock and pulls the data wire.
`timescale 1ns/1ps
`default_nettype none
module qps_bus_master #(
  parameter int HALF = 40
) (
  input  wire logic ref_clk,  // Timing reference.
  input  wire logic sda_line, // Resolved data wire.
  output logic      scl,      // Serial clock.
  output logic      sda_pull  // High pulls the data wire low.
);
  bit in_frame;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    in_frame = 1'b0;
  end

  task automatic quarter();
    repeat (HALF / 2) @(posedge ref_clk);
    #1;
  endtask

  task automatic clock_bit(input logic b, output logic s);
    scl = 1'b0;
    quarter();
    sda_pull = ~b;
    quarter();
    scl = 1'b1;
    quarter();
    s = sda_line;
    quarter();
  endtask

  task automatic start();
    if (in_frame) begin
      scl = 1'b0;
      quarter();
      sda_pull = 1'b0;
      quarter();
      scl = 1'b1;
      quarter();
    end
    sda_pull = 1'b1;
    quarter();
    in_frame = 1'b1;
  endtask

  task automatic stop();
    scl = 1'b0;
    quarter();
    sda_pull = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_pull = 1'b0;
    quarter();
    in_frame = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, ack);
  endtask

  task automatic read_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(~give_ack, s);
  endtask
endmodule
`default_nettype wire

//--- tb/quad_pot_serial_slave_tb.sv
// Self-checking bench of the quad potentiometer serial slave.
`timescale 1ns/1ps
`default_nettype none
module quad_pot_serial_slave_tb;
  import qps_pkg::*;
  localparam int         WR_CYC = 2000;
  localparam logic [3:0] DEV    = 4'h6; // Arbitrary device-type nibble.
  localparam int         LIMIT  = 95000;
  logic                      ref_clk;
  logic                      link_clk;
  logic                      rst_n;
  logic                      scl;
  logic                      sda_pull;
  logic                      sda_o;
  logic                      sda_oe_n;
  logic                      write_busy;
  logic [3:0]                pins;
  logic [POTS-1:0][TAPS-1:0] tap_en;
  int                        error_cnt;
  int                        total_checks;
  int                        cycles = 0;
  // The data wire has a pull-up; either party may pull it low.
  wire sda_line = ~(sda_pull | (~sda_oe_n & ~sda_o));

  qps_serial_slave #(.WR_CYCLES(WR_CYC), .DEV_TYPE(DEV)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_select_pins(pins), .tap_en(tap_en),
    .write_busy(write_busy));
  qps_bus_master #(.HALF(40)) u_master (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_vec(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] addr_byte();
    return {DEV, pins};
  endfunction

  task automatic frame(input logic [7:0] addr, input logic [7:0] cmd, input logic [7:0] dat,
                       input int nbytes, input logic [2:0] exp);
    logic a;
    u_master.start();
    u_master.write_byte(addr, a);
    check_bit("address ack", exp[0], a);
    u_master.write_byte(cmd, a);
    check_bit("command ack", exp[1], a);
    if (nbytes > 2) begin
      u_master.write_byte(dat, a);
      check_bit("data ack", exp[2], a);
    end
    u_master.stop();
  endtask

  task automatic read_reg(input logic [7:0] cmd, input logic [7:0] exp);
    logic       a;
    logic [7:0] d;
    u_master.start();
    u_master.write_byte(addr_byte(), a);
    check_bit("read address ack", 1'b0, a);
    u_master.write_byte(cmd, a);
    check_bit("read command ack", 1'b0, a);
    u_master.read_byte(1'b0, d);
    u_master.stop();
    check_vec("read data", {56'h0, exp}, {56'h0, d});
  endtask

  task automatic t_reset();
    for (int p = 0; p < POTS; p++) check_vec("tap reset", 64'h1, tap_en[p]);
    check_bit("busy reset", 1'b0, write_busy);
    check_bit("data released", 1'b1, sda_oe_n);
    $display("test reset done");
  endtask

  task automatic t_wiper();
    logic [5:0] vals [4] = '{6'h3F, 6'h00, 6'h2A, 6'h01};
    for (int p = 0; p < POTS; p++) begin
      frame(addr_byte(), {4'hA, 2'(p), 2'h0}, {2'h0, vals[p]}, 3, 3'b000);
      repeat (40) @(posedge ref_clk);
      check_vec("wiper taps", 64'h1 << vals[p], tap_en[p]);
      check_bit("single switch", 1'b1, $countones(tap_en[p]) == 1);
    end
    $display("test wiper done");
  endtask

  task automatic t_address();
    frame({DEV, pins ^ 4'h1}, 8'hA0, 8'h05, 3, 3'b111);
    frame({DEV ^ 4'hF, pins}, 8'hA0, 8'h05, 3, 3'b111);
    check_vec("taps after refusal", 64'h1 << 63, tap_en[0]);
    @(posedge ref_clk);
    #1;
    pins = 4'h3;
    repeat (10) @(posedge ref_clk);
    frame({DEV, 4'h3}, 8'hA0, 8'h07, 3, 3'b000);
    check_vec("taps new address", 64'h1 << 7, tap_en[0]);
    pins = 4'h9;
    repeat (10) @(posedge ref_clk);
    frame(addr_byte(), 8'h30, 8'h00, 2, 3'b010);
    $display("test address done");
  endtask

  task automatic t_nvwrite();
    int   n;
    logic a;
    for (int p = 0; p < POTS; p++) begin
      frame(addr_byte(), {4'hC, 2'(p), 2'h1}, 8'h10 + 8'(p), 3, 3'b000);
      n = 0;
      while (write_busy !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        n++;
      end
      check_bit("write busy", 1'b1, write_busy);
      n = 0;
      a = 1'b1;
      while (a !== 1'b0 && n < 20) begin
        u_master.start();
        u_master.write_byte(addr_byte(), a);
        u_master.stop();
        if (a !== 1'b0) n++;
      end
      check_bit("busy refused", 1'b1, n > 0);
      check_bit("poll ack", 1'b0, a);
    end
    frame(addr_byte(), 8'h11, 8'h00, 2, 3'b000);
    repeat (40) @(posedge ref_clk);
    for (int p = 0; p < POTS; p++) check_vec("global taps", 64'h1 << (16 + p), tap_en[p]);
    read_reg(8'hB9, 8'h12);
    read_reg(8'h9C, 8'h13);
    $display("test nonvolatile done");
  endtask

  task automatic t_abort();
    logic       s;
    logic [7:0] ad;
    ad = addr_byte();
    u_master.start();
    u_master.write_byte(ad, s);
    u_master.write_byte(8'hA4, s);
    for (int i = 0; i < 4; i++) u_master.clock_bit(1'b1, s);
    u_master.stop();
    repeat (40) @(posedge ref_clk);
    check_vec("taps after abort", 64'h1 << 17, tap_en[1]);
    for (int i = 7; i >= 0; i--) u_master.clock_bit(ad[i], s);
    u_master.clock_bit(1'b1, s);
    check_bit("no start no ack", 1'b1, s);
    frame(ad, 8'hA4, 8'h22, 3, 3'b000);
    check_vec("taps recovered", 64'h1 << 34, tap_en[1]);
    $display("test abort done");
  endtask

  initial begin
    rst_n        = 1'b0;
    pins         = 4'h9;
    error_cnt    = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    t_reset();
    t_wiper();
    t_address();
    t_nvwrite();
    t_abort();
    complete_run();
  end
endmodule
`default_nettype wire
